// [ac_link_serial_frame_port.sv]
// AC-link serial frame port: APB registers, frame sync, slot buffering
//
// How it works
// - Frame is 256 bits: tag plus twelve slots
// - Codec clocks us; we drive frame sync
// - Sync high 16 bits, low 240
// - First data bit one bit after sync
// - Receiver samples on falling bit clock
// - Mode 10 is 16-bit, 11 is 20-bit
// - 16-bit mode truncates received slots
// - 16-bit mode pads four zero LSBs
// - 16-bit mode keeps protocol slot alignment
// - 20-bit mode uses sixteen 16-bit slots
// - 20-bit mode behaves like multi-channel mode
// - Buffer holds four words, 64 bits
// - Current slot readable in status
// - Word size and frame length ignored
// - 16-bit mode uses enables 12:0 only
// - Length 00: done every word
// - Length 1: done every two words
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "ac_link_regs.svh"
module ac_link_serial_frame_port
(
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESETN,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // AC-link pins
  input  wire logic        I_SERIAL_BIT_CLOCK,
  input  wire logic        I_SDATA_IN,
  output logic             O_FRAME_SYNC_PIN,
  output logic             O_FRAME_SYNC_OE,
  output logic             O_SDATA_OUT,
  output logic             O_SDATA_OE,
  // Buffer events
  output logic             O_BUF_DONE
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ac_link_pkg::word_type      ctrl1_reg;
  ac_link_pkg::word_type      ctrl2_reg;
  ac_link_pkg::word_type      divider_reg;
  ac_link_pkg::word_type      tx_slot_reg;
  ac_link_pkg::word_type      rx_slot_reg;
  ac_link_pkg::word_type      tx_buf_reg [`BUF_WORDS];
  ac_link_pkg::word_type      rx_buf_reg [`BUF_WORDS];
  ac_link_pkg::word_type      rx_shadow_reg [`BUF_WORDS];
  ac_link_pkg::word_type      rx_shift_reg;
  ac_link_pkg::word_type      tx_mask;
  ac_link_pkg::word_type      rx_mask;
  ac_link_pkg::word_type      store_word;
  ac_link_pkg::link_mode_type link_mode;
  logic [7:0]                 cnt_reg;
  logic [7:0]                 cnt_next;
  logic [3:0]                 slot_reg;
  logic [3:0]                 slot_next;
  logic [4:0]                 bit_reg;
  logic [4:0]                 bit_next;
  logic [4:0]                 bit_last;
  logic [1:0]                 ptr_reg;
  logic [1:0]                 buffer_length_sel;
  logic                       active_reg;
  logic                       active_next;
  logic                       fs_reg;
  logic                       fs_oe_reg;
  logic                       sdo_reg;
  logic                       sdo_oe_reg;
  logic                       done_reg;
  logic                       done_flag_reg;
  logic                       run;
  logic                       ac16;
  logic                       bclk_rise;
  logic                       bclk_fall;
  logic                       sdi;
  logic                       tx_on_next;
  logic                       rx_on;
  logic                       store_evt;
  logic                       apb_setup;
  logic                       apb_write;
  logic [31:0]                prdata_reg;
  logic [31:0]                rdata_next;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic                       err_next;

  ac_link_pin_sync pin_sync
  (
    .i_clock     (I_CLOCK),
    .i_resetn    (I_RESETN),
    .i_bit_clock (I_SERIAL_BIT_CLOCK),
    .i_sdata     (I_SDATA_IN),
    .o_rise      (bclk_rise),
    .o_fall      (bclk_fall),
    .o_sdata     (sdi)
  );

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (ctrl1_reg[`MODE_LSB +: 2])
      `MODE_AC16: link_mode = ac_link_pkg::LINK_AC16;
      `MODE_AC20: link_mode = ac_link_pkg::LINK_AC20;
      default:    link_mode = ac_link_pkg::LINK_OFF;
    endcase
  end

  // Word size and frame length fields are stored but never read here
  assign ac16 = (link_mode == ac_link_pkg::LINK_AC16);
  assign run  = ctrl1_reg[`BIT_PORT_ENABLE] && (link_mode != ac_link_pkg::LINK_OFF);
  assign buffer_length_sel = ctrl2_reg[`BUFFER_LENGTH_SEL_LSB +: 2];
  assign tx_mask = ac16 ? (tx_slot_reg & `AC16_SLOT_MASK) : tx_slot_reg;
  assign rx_mask = ac16 ? (rx_slot_reg & `AC16_SLOT_MASK) : rx_slot_reg;

  // ----------------------------------------------------------------------
  // Frame counter and frame sync
  // ----------------------------------------------------------------------
  assign cnt_next = cnt_reg + 8'h01;

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN || !run)
      cnt_reg <= `FRAME_LAST_COUNT;
    else if (bclk_rise)
      cnt_reg <= cnt_next;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN || !run)
      fs_reg <= 1'b0;
    else if (bclk_rise)
      fs_reg <= (cnt_next < `FS_HIGH_BITS);
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      fs_oe_reg <= 1'b0;
    else
      fs_oe_reg <= run && !ctrl1_reg[`BIT_FS_DIRECTION];
  end

  // ----------------------------------------------------------------------
  // Slot and bit position
  // ----------------------------------------------------------------------
  // Tag slot is 16 bits; in 16-bit mode the data slots are 20 bits wide
  assign bit_last = (ac16 && slot_reg != 4'h0) ? `WIDE_LAST_BIT : `WORD_LAST_BIT;

  always_comb
  begin
    slot_next   = slot_reg;
    bit_next    = bit_reg;
    active_next = active_reg;
    if (cnt_next == 8'h01)
    begin
      active_next = 1'b1;
      slot_next   = 4'h0;
      bit_next    = 5'h00;
    end
    else if (bit_reg == bit_last)
    begin
      bit_next  = 5'h00;
      slot_next = slot_reg + 4'h1;
    end
    else
    begin
      bit_next = bit_reg + 5'h01;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN || !run)
    begin
      active_reg <= 1'b0;
      slot_reg   <= 4'h0;
      bit_reg    <= 5'h00;
    end
    else if (bclk_rise)
    begin
      active_reg <= active_next;
      slot_reg   <= slot_next;
      bit_reg    <= bit_next;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit, launched on the rising bit clock
  // ----------------------------------------------------------------------
  assign tx_on_next = active_next && tx_mask[slot_next];

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN || !run)
    begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end
    else if (bclk_rise)
    begin
      // Bits 16..19 of a wide slot go out as zero
      if (tx_on_next && bit_next <= `WORD_LAST_BIT)
        sdo_reg <= tx_buf_reg[ptr_reg][4'hF - bit_next[3:0]];
      else
        sdo_reg <= 1'b0;
      sdo_oe_reg <= !ctrl1_reg[`BIT_IDLE_MODE] || tx_on_next;
    end
  end

  // ----------------------------------------------------------------------
  // Receive, sampled on the falling bit clock
  // ----------------------------------------------------------------------
  assign rx_on     = active_reg && rx_mask[slot_reg];
  assign store_evt = bclk_fall && active_reg && bit_reg == bit_last
                     && (tx_mask[slot_reg] || rx_mask[slot_reg]);

  always_comb
  begin
    store_word = 16'h0000;
    if (rx_on)
      store_word = (bit_reg <= `WORD_LAST_BIT) ? {rx_shift_reg[14:0], sdi} : rx_shift_reg;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      rx_shift_reg <= 16'h0000;
    else if (bclk_fall && rx_on && bit_reg <= `WORD_LAST_BIT)
      rx_shift_reg <= {rx_shift_reg[14:0], sdi};
  end

  // Buffer pointer: one word per used slot, done after buffer_length_sel+1 words
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN || !run)
    begin
      ptr_reg  <= 2'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (store_evt)
      begin
        rx_shadow_reg[ptr_reg] <= store_word;
        if (ptr_reg == buffer_length_sel)
        begin
          ptr_reg  <= 2'h0;
          done_reg <= 1'b1;
        end
        else
          ptr_reg <= ptr_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Buffer words
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `BUF_WORDS; i++)
  begin : g_buf
    always_ff @(posedge I_CLOCK)
    begin
      if (!I_RESETN)
      begin
        tx_buf_reg[i] <= `REG_RESET;
        rx_buf_reg[i] <= `REG_RESET;
      end
      else
      begin
        if (apb_write && I_PADDR == `OFS_TX_BUF_BASE + 8'(4 * i))
          tx_buf_reg[i] <= I_PWDATA[15:0];
        // Whole block becomes visible at once, when the last word lands
        if (store_evt && ptr_reg == buffer_length_sel)
          rx_buf_reg[i] <= (ptr_reg == 2'(i)) ? store_word : rx_shadow_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------------
  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_write = I_PSEL && I_PENABLE && pready_reg && I_PWRITE;

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      ctrl1_reg   <= `REG_RESET;
      ctrl2_reg   <= `REG_RESET;
      divider_reg <= `REG_RESET;
      tx_slot_reg <= `REG_RESET;
      rx_slot_reg <= `REG_RESET;
    end
    else if (apb_write)
    begin
      unique case (I_PADDR)
        `OFS_CONTROL_ONE:   ctrl1_reg   <= I_PWDATA[15:0];
        `OFS_CONTROL_TWO:   ctrl2_reg   <= I_PWDATA[15:0];
        `OFS_CLOCK_DIVIDER: divider_reg <= I_PWDATA[15:0];
        `OFS_TX_SLOTS:      tx_slot_reg <= I_PWDATA[15:0];
        `OFS_RX_SLOTS:      rx_slot_reg <= I_PWDATA[15:0];
        default:            ;
      endcase
    end
  end

  // Completion beats a same-cycle write-one-to-clear
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      done_flag_reg <= 1'b0;
    else if (done_reg)
      done_flag_reg <= 1'b1;
    else if (apb_write && I_PADDR == `OFS_STATUS && I_PWDATA[`STAT_DONE])
      done_flag_reg <= 1'b0;
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    unique case (I_PADDR)
      `OFS_CONTROL_ONE:   rdata_next[15:0] = ctrl1_reg;
      `OFS_CONTROL_TWO:   rdata_next[15:0] = ctrl2_reg;
      `OFS_CLOCK_DIVIDER: rdata_next[15:0] = divider_reg;
      `OFS_TX_SLOTS:      rdata_next[15:0] = tx_slot_reg;
      `OFS_RX_SLOTS:      rdata_next[15:0] = rx_slot_reg;
      `OFS_STATUS:
      begin
        rdata_next[`STAT_SLOT_LSB +: 5] = {1'b0, slot_reg};
        rdata_next[`STAT_ACTIVE]        = active_reg;
        rdata_next[`STAT_DONE]          = done_flag_reg;
      end
      8'h20, 8'h24, 8'h28, 8'h2C: rdata_next[15:0] = tx_buf_reg[I_PADDR[3:2]];
      8'h30, 8'h34, 8'h38, 8'h3C: rdata_next[15:0] = rx_buf_reg[I_PADDR[3:2]];
      default: err_next = 1'b1;
    endcase
  end

  // Zero-wait slave: data is captured in setup, ready in the access cycle
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= apb_setup;
      if (apb_setup)
      begin
        prdata_reg  <= I_PWRITE ? 32'h0000_0000 : rdata_next;
        pslverr_reg <= err_next;
      end
    end
  end

  assign O_PRDATA         = prdata_reg;
  assign O_PREADY         = pready_reg;
  assign O_PSLVERR        = pslverr_reg;
  assign O_FRAME_SYNC_PIN = fs_reg;
  assign O_FRAME_SYNC_OE  = fs_oe_reg;
  assign O_SDATA_OUT      = sdo_reg;
  assign O_SDATA_OE       = sdo_oe_reg;
  assign O_BUF_DONE       = done_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_fs_rise_start: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    $rose(fs_reg) |-> cnt_reg == 8'h00)
    else $error("frame sync rose away from frame start");

  a_fs_fall_point: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    $fell(fs_reg) && run |-> cnt_reg == `FS_HIGH_BITS)
    else $error("frame sync high time is not 16 bits");

  a_frame_wrap: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    run && bclk_rise && cnt_reg == 8'hFF ##1 run |-> cnt_reg == 8'h00 && fs_reg)
    else $error("frame did not wrap after 256 bits");

  a_first_bit_pos: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    run && $changed(cnt_reg) && cnt_reg == 8'h01 |-> slot_reg == 4'h0 && bit_reg == 5'h00)
    else $error("first data bit not one bit after sync");

  a_pad_zero_lsbs: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ac16 && active_reg && bit_reg > `WORD_LAST_BIT |-> !sdo_reg)
    else $error("padding bits of wide slot not zero");

  a_ac16_slot_len: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    run && ac16 && bclk_rise && active_reg && slot_reg != 4'h0 && slot_reg < `AC16_LAST_SLOT
    && bit_reg == `WIDE_LAST_BIT ##1 run |-> bit_reg == 5'h00 && slot_reg == $past(slot_reg) + 4'h1)
    else $error("wide slot not 20 bits");

  a_ac16_slot_cap: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    ac16 |-> slot_reg <= `AC16_LAST_SLOT)
    else $error("16-bit mode slot index past 12");

  a_ac20_word_len: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    link_mode == ac_link_pkg::LINK_AC20 |-> bit_reg <= `WORD_LAST_BIT)
    else $error("20-bit mode slot longer than 16 bits");

  a_rx_fall_only: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    $changed(rx_shift_reg) |-> $past(bclk_fall))
    else $error("receive sampled off the falling edge");

  a_done_count: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    done_reg |-> ptr_reg == 2'h0 && $past(ptr_reg) == $past(buffer_length_sel))
    else $error("buffer done after wrong word count");
endmodule

// [ac_link_regs.svh]
// Register offsets, field positions and frame timing for the AC-link port
`ifndef AC_LINK_REGS_SVH
`define AC_LINK_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONTROL_TWO   8'h04
`define OFS_CLOCK_DIVIDER 8'h08
`define OFS_STATUS        8'h0C
`define OFS_TX_SLOTS      8'h10
`define OFS_RX_SLOTS      8'h14
`define OFS_TX_BUF_BASE   8'h20
`define OFS_RX_BUF_BASE   8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PORT_ENABLE   15
`define BIT_IDLE_MODE     6
`define BIT_FS_DIRECTION  8
`define MODE_LSB          0
`define BUFFER_LENGTH_SEL_LSB          10
`define STAT_DONE         0
`define STAT_ACTIVE       1
`define STAT_SLOT_LSB     7

// ----------------------------------------------------------------------
// Encodings, sizes and reset values
// ----------------------------------------------------------------------
`define MODE_AC16         2'h2
`define MODE_AC20         2'h3
`define AC16_SLOT_MASK    16'h1FFF
`define FRAME_LAST_COUNT  8'hFF
`define FS_HIGH_BITS      8'h10
`define WORD_LAST_BIT     5'h0F
`define WIDE_LAST_BIT     5'h13
`define AC16_LAST_SLOT    4'hC
`define BUF_WORDS         4
`define REG_RESET         16'h0000
`endif

// [ac_link_pkg.sv]
// Types shared by the AC-link port modules
package ac_link_pkg;
  typedef logic [15:0] word_type;
  typedef enum logic [1:0] {LINK_OFF, LINK_AC16, LINK_AC20} link_mode_type;
endpackage

// [ac_link_pin_sync.sv]
// Synchroniser and edge finder for the codec bit clock and serial data
`timescale 1ns/10ps
module ac_link_pin_sync
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // Pins from the codec
  input  wire logic i_bit_clock,
  input  wire logic i_sdata,
  // Synchronised view
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_sdata
);

  logic clk_meta_reg;
  logic clk_sync_reg;
  logic clk_last_reg;
  logic dat_meta_reg;
  logic dat_sync_reg;

  // Data takes the same two stages as the clock, so sampling stays aligned
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_last_reg <= 1'b0;
      dat_meta_reg <= 1'b0;
      dat_sync_reg <= 1'b0;
    end
    else
    begin
      clk_meta_reg <= i_bit_clock;
      clk_sync_reg <= clk_meta_reg;
      clk_last_reg <= clk_sync_reg;
      dat_meta_reg <= i_sdata;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  assign o_rise  = clk_sync_reg & ~clk_last_reg;
  assign o_fall  = ~clk_sync_reg & clk_last_reg;
  assign o_sdata = dat_sync_reg;
endmodule

// [ac_link_codec_model.sv]
// Behavioural codec at the far side of the link: bit clock, framed data both ways
`timescale 1ns/10ps
module ac_link_codec_model
#(
  parameter int HALF_NS = 100
)
(
  // Link pins
  output logic         o_bit_clock,
  output logic         o_sdata,
  input  wire logic    i_frame_sync,
  input  wire logic    i_sdata,
  input  wire logic    i_sdata_oe,
  // Observed traffic
  output logic [255:0] o_frame_in,
  output int           o_frames
);
  // -----------------------------------------------------------------
  // Fixed frame sent to the port
  // -----------------------------------------------------------------
  localparam logic [255:0] PATTERN = {8{32'hC3A596E1}};
  logic [7:0] cnt;
  logic [7:0] nxt;
  logic       sync_d;

  initial
  begin
    o_bit_clock = 1'b0;
    o_sdata = 1'b0;
    cnt = 8'h00;
    sync_d = 1'b0;
    o_frames = 0;
    o_frame_in = '0;
  end

  // Codec owns the bit clock; it runs free, as a real codec does
  always #(HALF_NS) o_bit_clock = ~o_bit_clock;

  // Port data is taken falling, half a bit after the port launches it
  always @(negedge o_bit_clock)
    if (i_sdata_oe)
      o_frame_in[8'hFF - cnt] <= i_sdata;

  // Data changes on the rising edge so the port can take it falling
  always @(posedge o_bit_clock)
  begin
    nxt = (i_frame_sync && !sync_d) ? 8'h00 : cnt + 8'h01;
    if (i_frame_sync && !sync_d)
      o_frames <= o_frames + 1;
    o_sdata <= PATTERN[8'hFF - nxt];
    cnt <= nxt;
    sync_d <= i_frame_sync;
  end
endmodule

// [testbench.sv]
// Self-checking bench for the AC-link serial frame port
`timescale 1ns/10ps
`include "ac_link_regs.svh"
module testbench;
  logic         clock;
  logic         resetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         bclk;
  logic         sdi;
  logic         fs;
  logic         fs_oe;
  logic         sdo;
  logic         sdo_oe;
  logic         done;
  logic [255:0] frame_in;
  int           frames;
  int           err_count;
  int           n_compared;
  int           hi_len;
  int           lo_len;
  int           hi_run;
  int           lo_run;
  int           dones;
  int           dmark;
  int           per_frame;
  logic         fs_d;
  logic [31:0]  rd;
  logic         rerr;
  logic [4:0]   s1;

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  ac_link_serial_frame_port DUT (.I_CLOCK(clock), .I_RESETN(resetn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SERIAL_BIT_CLOCK(bclk), .I_SDATA_IN(sdi), .O_FRAME_SYNC_PIN(fs),
    .O_FRAME_SYNC_OE(fs_oe), .O_SDATA_OUT(sdo), .O_SDATA_OE(sdo_oe), .O_BUF_DONE(done));

  ac_link_codec_model codec (.o_bit_clock(bclk), .o_sdata(sdi), .i_frame_sync(fs),
    .i_sdata(sdo), .i_sdata_oe(sdo_oe), .o_frame_in(frame_in), .o_frames(frames));

  // -----------------------------------------------------------------
  // Monitors: sync shape and done pulses per frame
  // -----------------------------------------------------------------
  always @(posedge clock)
    if (done === 1'b1)
      dones <= dones + 1;

  always @(posedge bclk)
  begin
    if (fs === 1'b1 && fs_d !== 1'b1)
    begin
      lo_len = lo_run;
      per_frame = dones - dmark;
      dmark = dones;
      hi_run = 1;
    end
    else if (fs === 1'b1)
      hi_run = hi_run + 1;
    else if (fs_d === 1'b1)
    begin
      hi_len = hi_run;
      lo_run = 1;
    end
    else
      lo_run = lo_run + 1;
    fs_d = fs;
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      check("pready", 32'h0, 32'h1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Frames take ~2048 clocks, so the bound leaves ample slack
  task automatic wait_frames(input int k);
    int f0;
    int n;
    f0 = frames;
    n = 0;
    while (frames < f0 + k && n < 3000 * k)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000 * k)
      check("frame wait", 32'h0, 32'h1);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000)
      check("done wait", 32'h0, 32'h1);
    @(posedge clock);
  endtask

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Watchdog and main sequence
  // -----------------------------------------------------------------
  initial
  begin
    #2_000_000;
    err_count++;
    end_of_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    {err_count, n_compared, hi_run, lo_run, hi_len, lo_len, dones, dmark} = '0;
    per_frame = 0;
    fs_d = 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, `OFS_CONTROL_ONE, 32'h0);
    check("ctrl1 reset", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", {31'h0, rerr}, 32'h1);
    check("unmapped data", rd, 32'h0);
    check("sync oe idle", {31'h0, fs_oe}, 32'h0);
    $display("Test registers done");
    // 16-bit mode, tag and slot 1, two words per block
    apb(1'b1, `OFS_TX_SLOTS, 32'h3);
    apb(1'b1, `OFS_RX_SLOTS, 32'h3);
    apb(1'b1, `OFS_CLOCK_DIVIDER, 32'h0);
    apb(1'b1, `OFS_CONTROL_TWO, 32'h0400);
    apb(1'b1, `OFS_TX_BUF_BASE, 32'h1234);
    apb(1'b1, `OFS_TX_BUF_BASE + 8'h04, 32'hABCD);
    apb(1'b1, `OFS_CONTROL_ONE, 32'h8402);
    wait_frames(3);
    check("tag slot out", {16'h0, frame_in[255:240]}, 32'h1234);
    check("slot1 out", {12'h0, frame_in[239:220]}, 32'hABCD0);
    check("sync oe", {31'h0, fs_oe}, 32'h1);
    check("sdata oe", {31'h0, sdo_oe}, 32'h1);
    check("sync high", hi_len, 16);
    check("sync low", lo_len, 240);
    check("done per frame", per_frame, 1);
    wait_done();
    apb(1'b0, `OFS_RX_BUF_BASE, 32'h0);
    check("rx tag", rd, 32'hC3A5);
    apb(1'b0, `OFS_RX_BUF_BASE + 8'h04, 32'h0);
    check("rx slot1", rd, 32'h96E1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("done flag", {31'h0, rd[0]}, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("done cleared", {31'h0, rd[0]}, 32'h0);
    apb(1'b1, `OFS_CONTROL_TWO, 32'h0);
    wait_frames(2);
    check("done per word", per_frame, 2);
    $display("Test 16-bit mode done");
    // 20-bit mode, all slots packed, four words per block
    // Stop first: a live mode change leaves slot, bit and pointer mid-frame
    apb(1'b1, `OFS_CONTROL_ONE, 32'h0);
    apb(1'b1, `OFS_TX_SLOTS, 32'hFFFF);
    apb(1'b1, `OFS_RX_SLOTS, 32'hFFFF);
    apb(1'b1, `OFS_TX_BUF_BASE + 8'h08, 32'h3333);
    apb(1'b1, `OFS_TX_BUF_BASE + 8'h0C, 32'h4444);
    apb(1'b1, `OFS_TX_BUF_BASE, 32'h1111);
    apb(1'b1, `OFS_TX_BUF_BASE + 8'h04, 32'h2222);
    apb(1'b1, `OFS_CONTROL_TWO, 32'h0C00);
    apb(1'b1, `OFS_CONTROL_ONE, 32'h8403);
    wait_frames(3);
    check("packed head", frame_in[255:224], 32'h11112222);
    check("packed tail", frame_in[31:0], 32'h33334444);
    check("sync high ac20", hi_len, 16);
    check("sync low ac20", lo_len, 240);
    check("blocks per frame", per_frame, 4);
    wait_done();
    apb(1'b0, `OFS_RX_BUF_BASE + 8'h08, 32'h0);
    check("rx packed", rd, 32'hC3A5);
    repeat (60) @(posedge clock);
    apb(1'b0, `OFS_STATUS, 32'h0);
    s1 = rd[11:7];
    // Captures exactly one 128-clock slot apart, so one boundary lies between
    repeat (125) @(posedge clock);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("slot advance", {27'h0, rd[11:7]}, {28'h0, s1[3:0] + 4'h1});
    $display("Test 20-bit mode done");
    apb(1'b1, `OFS_CONTROL_ONE, 32'h8001);
    repeat (10) @(posedge clock);
    check("sync oe off", {31'h0, fs_oe}, 32'h0);
    check("sync off", {31'h0, fs}, 32'h0);
    $display("Test mode off done");
    end_of_test();
  end
endmodule
